// ### hdl/pwr_pkg.sv
// Constants, types and command codes of the power-state controller.
// Assumes a 50 MHz core clock; link and pin inputs are synchronised.
// What this block does
// - Power-up reset ends in SLEEP state
// - ACTIVE command moves device into ACTIVE
// - Engines run only in ACTIVE
// - Commands enter STANDBY, SLEEP or POWERDOWN
// - Power-down pin low in ACTIVE enters POWERDOWN
// - ACTIVE runs oscillator, PLL, core clock
// - STANDBY keeps oscillator, PLL; gates core clock
// - SLEEP stops oscillator, PLL, core clock; retains
// - POWERDOWN stops clocks, powers core off
// - Command powerdown exits by ACTIVE, pin high
// - Pin powerdown exits by pin high, ACTIVE
// - Leaving POWERDOWN: global reset, keep pin states
// - STANDBY wake allows immediate access
// - Power-on reset clears all core logic
// - 5ms pin low pulse resets in ACTIVE/STANDBY
// - Resistive touch pulls interrupt in STANDBY/SLEEP
// - Capacitive interrupt mirrored outside ACTIVE
// - Boot takes up to 300ms after ACTIVE
// - Soft reset on pulse command or leaving command-powerdown
// - Pins hold state entering STANDBY or SLEEP
package pwr_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned HZ_PER_KHZ = 1000;
  localparam int unsigned PD_PULSE_MS = 5;
  localparam int unsigned PD_PULSE_CYC = PD_PULSE_MS * (CLK_HZ / HZ_PER_KHZ);
  localparam int unsigned BOOT_MS = 300;
  localparam int unsigned BOOT_CYC = BOOT_MS * (CLK_HZ / HZ_PER_KHZ);
  localparam int unsigned CNT_W = 24;

  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned BIT_CNT_W = 5;

  // Host command opcodes, first byte of a three-byte frame
  localparam logic [7:0] CMD_ACTIVE = 8'h00;
  localparam logic [7:0] CMD_STANDBY = 8'h01;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [7:0] CMD_PWRDOWN = 8'h03;
  localparam logic [7:0] CMD_RST_PULSE = 8'h04;
  localparam logic [7:0] CMD_CLK_EXT = 8'h05;
  localparam logic [7:0] CMD_PIN_PD = 8'h06;
  localparam logic [7:0] PIN_PD_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_STANDBY = 2'b01,
    ST_SLEEP = 2'b10,
    ST_POWERDOWN = 2'b11
  } pwr_state_t;

  typedef struct packed {
    logic osc_en;
    logic pll_en;
    logic sys_clk_en;
    logic engines_en;
    logic core_pwr_en;
  } clk_ctrl_t;

  localparam clk_ctrl_t CTRL_ACTIVE = 5'h1F;
  localparam clk_ctrl_t CTRL_STANDBY = 5'h19;
  localparam clk_ctrl_t CTRL_SLEEP = 5'h01;
  localparam clk_ctrl_t CTRL_POWERDOWN = 5'h00;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] arg;
  } host_cmd_t;

endpackage

// ### hdl/level_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs are independent levels; no bus coherence.
`timescale 1ns/1ps
module level_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= RST_VAL;
      q_out <= RST_VAL;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// ### hdl/host_cmd_rx.sv
// Host command receiver: samples the synchronised link, one frame per
// select. Assumes sck is several core clocks per half period.
`timescale 1ns/1ps
module host_cmd_rx (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic cmd_valid_out,
  output pwr_pkg::host_cmd_t cmd_out
);
  localparam logic [pwr_pkg::BIT_CNT_W-1:0] FULL =
    pwr_pkg::FRAME_BITS[pwr_pkg::BIT_CNT_W-1:0];
  logic sck_prev_q;
  logic cs_prev_q;
  logic [pwr_pkg::FRAME_BITS-1:0] shift_q;
  logic [pwr_pkg::BIT_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      shift_q <= '0;
      cnt_q <= '0;
      cmd_valid_out <= 1'b0;
      cmd_out <= '0;
    end else if (ce_in) begin
      sck_prev_q <= sck_in;
      cs_prev_q <= cs_n_in;
      cmd_valid_out <= 1'b0;
      if (cs_n_in) begin
        cnt_q <= '0;
        // Only an exact three-byte frame is a command
        if (!cs_prev_q && cnt_q == FULL) begin
          cmd_valid_out <= 1'b1;
          cmd_out <= shift_q[pwr_pkg::FRAME_BITS-1 -: 16];
        end
      end else if (sck_in && !sck_prev_q) begin
        shift_q <= {shift_q[pwr_pkg::FRAME_BITS-2:0], mosi_in};
        if (cnt_q != FULL + 1'b1) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule

// ### hdl/power_state_controller.sv
// Power-state controller: state machine, clock gating and reset events.
// Assumes pins and the host link are asynchronous to clk_in.
`timescale 1ns/1ps
module power_state_controller #(
  parameter int unsigned PD_PULSE_CYCLES = pwr_pkg::PD_PULSE_CYC,
  parameter int unsigned BOOT_CYCLES = pwr_pkg::BOOT_CYC,
  parameter int unsigned CNT_W = pwr_pkg::CNT_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic por_n_in,
  input wire logic power_down_pin_n_in,
  input wire logic spi_sck_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  input wire logic touch_resistive_in,
  input wire logic touch_detect_in,
  input wire logic touch_panel_interrupt_input_n_in,
  input wire logic irq_req_in,
  output pwr_pkg::pwr_state_t power_state_out,
  output pwr_pkg::clk_ctrl_t clk_ctrl_out,
  output logic pin_hold_out,
  output logic boot_busy_out,
  output logic global_reset_out,
  output logic soft_reset_out,
  output logic clk_ext_out,
  output logic [7:0] pd_pin_state_out,
  output logic host_int_out,
  output logic host_int_oe_out
);
  localparam logic [CNT_W-1:0] PD_CNT_MAX = CNT_W'(PD_PULSE_CYCLES);
  localparam logic [CNT_W-1:0] BOOT_LOAD = CNT_W'(BOOT_CYCLES - 1);

  pwr_pkg::pwr_state_t state_q;
  pwr_pkg::pwr_state_t state_d;
  pwr_pkg::clk_ctrl_t ctrl_d;
  pwr_pkg::host_cmd_t cmd;
  logic cmd_valid;
  logic por_n_s;
  logic pd_n_s;
  logic cs_n_s;
  logic tp_int_n_s;
  logic sck_s;
  logic mosi_s;
  logic touch_s;
  logic pd_prev_q;
  logic pd_arm_q;
  logic pd_by_cmd_q;
  logic [CNT_W-1:0] pd_cnt_q;
  logic [CNT_W-1:0] boot_cnt_q;
  logic por_hit;
  logic hw_reset;
  logic pd_exit;
  logic boot_start;
  logic soft_evt;
  logic int_drive;

  level_sync #(
    .W(4),
    .RST_VAL(4'hF)
  ) u_sync_hi (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .d_in({por_n_in, power_down_pin_n_in, spi_cs_n_in,
           touch_panel_interrupt_input_n_in}),
    .q_out({por_n_s, pd_n_s, cs_n_s, tp_int_n_s})
  );

  level_sync #(
    .W(3),
    .RST_VAL(3'h0)
  ) u_sync_lo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .d_in({spi_sck_in, spi_mosi_in, touch_detect_in}),
    .q_out({sck_s, mosi_s, touch_s})
  );

  host_cmd_rx u_cmd_rx (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .sck_in(sck_s),
    .cs_n_in(cs_n_s),
    .mosi_in(mosi_s),
    .cmd_valid_out(cmd_valid),
    .cmd_out(cmd)
  );

  assign por_hit = !por_n_s;
  // Low pulse long enough, begun in ACTIVE or STANDBY, ends in reset
  assign hw_reset = pd_n_s && !pd_prev_q && pd_arm_q
                    && pd_cnt_q >= PD_CNT_MAX;

  // Next power state
  always_comb begin
    state_d = state_q;
    if (hw_reset) begin
      state_d = pwr_pkg::ST_SLEEP;
    end else begin
      unique case (state_q)
        pwr_pkg::ST_ACTIVE: begin
          if (!pd_n_s) begin
            state_d = pwr_pkg::ST_POWERDOWN;
          end else if (cmd_valid) begin
            if (cmd.op == pwr_pkg::CMD_STANDBY) begin
              state_d = pwr_pkg::ST_STANDBY;
            end else if (cmd.op == pwr_pkg::CMD_SLEEP) begin
              state_d = pwr_pkg::ST_SLEEP;
            end else if (cmd.op == pwr_pkg::CMD_PWRDOWN) begin
              state_d = pwr_pkg::ST_POWERDOWN;
            end
          end
        end
        pwr_pkg::ST_STANDBY, pwr_pkg::ST_SLEEP: begin
          if (cmd_valid) begin
            if (cmd.op == pwr_pkg::CMD_ACTIVE) begin
              state_d = pwr_pkg::ST_ACTIVE;
            end else if (cmd.op == pwr_pkg::CMD_STANDBY) begin
              state_d = pwr_pkg::ST_STANDBY;
            end else if (cmd.op == pwr_pkg::CMD_SLEEP) begin
              state_d = pwr_pkg::ST_SLEEP;
            end else if (cmd.op == pwr_pkg::CMD_PWRDOWN) begin
              state_d = pwr_pkg::ST_POWERDOWN;
            end
          end
        end
        pwr_pkg::ST_POWERDOWN: begin
          // Either entry path needs the pin high before ACTIVE counts
          if (cmd_valid && cmd.op == pwr_pkg::CMD_ACTIVE && pd_n_s) begin
            state_d = pwr_pkg::ST_ACTIVE;
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (state_d)
      pwr_pkg::ST_ACTIVE: ctrl_d = pwr_pkg::CTRL_ACTIVE;
      pwr_pkg::ST_STANDBY: ctrl_d = pwr_pkg::CTRL_STANDBY;
      pwr_pkg::ST_SLEEP: ctrl_d = pwr_pkg::CTRL_SLEEP;
      pwr_pkg::ST_POWERDOWN: ctrl_d = pwr_pkg::CTRL_POWERDOWN;
    endcase
  end

  assign pd_exit = state_q == pwr_pkg::ST_POWERDOWN
                   && state_d == pwr_pkg::ST_ACTIVE;
  // STANDBY wake skips boot: clocks never stopped
  assign boot_start = state_d == pwr_pkg::ST_ACTIVE
                      && (state_q == pwr_pkg::ST_SLEEP || pd_exit);
  assign soft_evt = (cmd_valid && cmd.op == pwr_pkg::CMD_RST_PULSE
                     && state_q != pwr_pkg::ST_POWERDOWN)
                    || (pd_exit && pd_by_cmd_q);

  // State and clock controls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= pwr_pkg::ST_SLEEP;
      clk_ctrl_out <= pwr_pkg::CTRL_SLEEP;
      pin_hold_out <= 1'b1;
    end else if (ce_in) begin
      if (por_hit) begin
        state_q <= pwr_pkg::ST_SLEEP;
        clk_ctrl_out <= pwr_pkg::CTRL_SLEEP;
        pin_hold_out <= 1'b1;
      end else begin
        state_q <= state_d;
        clk_ctrl_out <= ctrl_d;
        pin_hold_out <= state_d == pwr_pkg::ST_STANDBY
                        || state_d == pwr_pkg::ST_SLEEP;
      end
    end
  end

  assign power_state_out = state_q;

  // Power-down pin pulse measurement
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pd_prev_q <= 1'b1;
      pd_arm_q <= 1'b0;
      pd_cnt_q <= '0;
    end else if (ce_in) begin
      pd_prev_q <= pd_n_s;
      if (por_hit || pd_n_s) begin
        pd_cnt_q <= '0;
      end else if (pd_cnt_q != PD_CNT_MAX) begin
        pd_cnt_q <= pd_cnt_q + 1'b1;
      end
      if (por_hit) begin
        pd_arm_q <= 1'b0;
      end else if (pd_prev_q && !pd_n_s) begin
        pd_arm_q <= state_q == pwr_pkg::ST_ACTIVE
                    || state_q == pwr_pkg::ST_STANDBY;
      end else if (pd_n_s) begin
        pd_arm_q <= 1'b0;
      end
    end
  end

  // Reset pulses and command settings
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      global_reset_out <= 1'b0;
      soft_reset_out <= 1'b0;
      pd_by_cmd_q <= 1'b0;
      clk_ext_out <= 1'b0;
      pd_pin_state_out <= pwr_pkg::PIN_PD_RST;
    end else if (ce_in) begin
      global_reset_out <= por_hit || hw_reset || pd_exit;
      soft_reset_out <= !por_hit && !hw_reset && soft_evt;
      if (por_hit || hw_reset) begin
        pd_by_cmd_q <= 1'b0;
        clk_ext_out <= 1'b0;
        pd_pin_state_out <= pwr_pkg::PIN_PD_RST;
      end else begin
        if (state_q != pwr_pkg::ST_POWERDOWN
            && state_d == pwr_pkg::ST_POWERDOWN) begin
          pd_by_cmd_q <= pd_n_s;
        end
        // Pin states for power-down survive the wake reset
        if (pd_exit) begin
          clk_ext_out <= 1'b0;
        end else if (cmd_valid && state_q != pwr_pkg::ST_POWERDOWN) begin
          if (cmd.op == pwr_pkg::CMD_CLK_EXT) begin
            clk_ext_out <= 1'b1;
          end
          if (cmd.op == pwr_pkg::CMD_PIN_PD) begin
            pd_pin_state_out <= cmd.arg;
          end
        end
      end
    end
  end

  // Boot window after wake from a stopped clock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      boot_busy_out <= 1'b0;
      boot_cnt_q <= '0;
    end else if (ce_in) begin
      if (por_hit || hw_reset || state_d != pwr_pkg::ST_ACTIVE) begin
        boot_busy_out <= 1'b0;
        boot_cnt_q <= '0;
      end else if (boot_start) begin
        boot_busy_out <= 1'b1;
        boot_cnt_q <= BOOT_LOAD;
      end else if (boot_busy_out) begin
        if (boot_cnt_q == '0) begin
          boot_busy_out <= 1'b0;
        end else begin
          boot_cnt_q <= boot_cnt_q - 1'b1;
        end
      end
    end
  end

  // Host interrupt pin, open drain: enable means pull low
  always_comb begin
    int_drive = 1'b0;
    unique case (state_q)
      pwr_pkg::ST_ACTIVE: int_drive = irq_req_in;
      pwr_pkg::ST_STANDBY, pwr_pkg::ST_SLEEP: begin
        int_drive = touch_resistive_in ? touch_s : !tp_int_n_s;
      end
      pwr_pkg::ST_POWERDOWN: begin
        int_drive = !touch_resistive_in && !tp_int_n_s;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      host_int_out <= 1'b0;
      host_int_oe_out <= 1'b0;
    end else if (ce_in) begin
      host_int_out <= 1'b0;
      host_int_oe_out <= int_drive && !por_hit;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_reset_to_sleep: assert property (
    $past(!rst_n_in) |-> state_q == pwr_pkg::ST_SLEEP)
    else $error("not in SLEEP after reset");
  a_active_cmd_wake: assert property (
    ce_in && cmd_valid && cmd.op == pwr_pkg::CMD_ACTIVE && !por_hit
    && !hw_reset && (state_q == pwr_pkg::ST_SLEEP
    || state_q == pwr_pkg::ST_STANDBY)
    |=> state_q == pwr_pkg::ST_ACTIVE)
    else $error("ACTIVE command did not wake");
  a_engines_active: assert property (
    clk_ctrl_out.engines_en |-> state_q == pwr_pkg::ST_ACTIVE)
    else $error("engines on outside ACTIVE");
  a_sleep_cmd_taken: assert property (
    ce_in && cmd_valid && cmd.op == pwr_pkg::CMD_SLEEP && pd_n_s
    && state_q == pwr_pkg::ST_ACTIVE && !por_hit
    |=> state_q == pwr_pkg::ST_SLEEP && pin_hold_out)
    else $error("SLEEP command not taken");
  a_pin_powerdown: assert property (
    ce_in && state_q == pwr_pkg::ST_ACTIVE && !pd_n_s && !por_hit
    && !hw_reset |=> state_q == pwr_pkg::ST_POWERDOWN)
    else $error("pin low did not power down");
  a_active_clocks: assert property (
    state_q == pwr_pkg::ST_ACTIVE |-> clk_ctrl_out == pwr_pkg::CTRL_ACTIVE)
    else $error("ACTIVE clocks wrong");
  a_standby_clocks: assert property (
    state_q == pwr_pkg::ST_STANDBY
    |-> clk_ctrl_out.osc_en && !clk_ctrl_out.sys_clk_en
    && clk_ctrl_out.core_pwr_en)
    else $error("STANDBY clocks wrong");
  a_sleep_pd_clocks: assert property (
    state_q inside {pwr_pkg::ST_SLEEP, pwr_pkg::ST_POWERDOWN}
    |-> !clk_ctrl_out.osc_en && !clk_ctrl_out.pll_en
    && clk_ctrl_out.core_pwr_en == (state_q == pwr_pkg::ST_SLEEP))
    else $error("SLEEP or POWERDOWN clocks wrong");
  a_pd_pin_gate: assert property (
    state_q == pwr_pkg::ST_POWERDOWN && !pd_n_s
    |=> state_q != pwr_pkg::ST_ACTIVE)
    else $error("woke with pin low");
  a_wake_reset: assert property (
    $past(state_q) == pwr_pkg::ST_POWERDOWN
    && state_q == pwr_pkg::ST_ACTIVE |-> global_reset_out && !clk_ext_out
    && $stable(pd_pin_state_out))
    else $error("wake from POWERDOWN without global reset");
  a_standby_no_boot: assert property (
    $past(state_q) == pwr_pkg::ST_STANDBY
    && state_q == pwr_pkg::ST_ACTIVE |-> !boot_busy_out)
    else $error("STANDBY wake blocked access");
  a_por_clears: assert property (
    ce_in && por_hit |=> state_q == pwr_pkg::ST_SLEEP && global_reset_out)
    else $error("power-on reset not applied");
  a_pulse_reset: assert property (
    ce_in && hw_reset && !por_hit
    |=> state_q == pwr_pkg::ST_SLEEP && global_reset_out)
    else $error("long pin pulse did not reset");
  a_resistive_int: assert property (
    ce_in && touch_resistive_in && touch_s && !por_hit
    && state_q == pwr_pkg::ST_SLEEP |=> host_int_oe_out)
    else $error("resistive touch not signalled");
  a_cap_mirror: assert property (
    ce_in && !touch_resistive_in && !por_hit
    && state_q == pwr_pkg::ST_POWERDOWN
    |=> host_int_oe_out == !$past(tp_int_n_s))
    else $error("capacitive interrupt not mirrored");
  a_boot_window: assert property (
    $rose(boot_busy_out) |-> boot_cnt_q == BOOT_LOAD)
    else $error("boot window length wrong");
  a_soft_reset: assert property (
    ce_in && cmd_valid && cmd.op == pwr_pkg::CMD_RST_PULSE && !por_hit
    && !hw_reset && state_q != pwr_pkg::ST_POWERDOWN |=> soft_reset_out)
    else $error("soft reset command ignored");
  a_active_idem: assert property (
    ce_in && cmd_valid && cmd.op == pwr_pkg::CMD_ACTIVE && pd_n_s
    && !por_hit && !hw_reset && state_q == pwr_pkg::ST_ACTIVE
    |=> state_q == pwr_pkg::ST_ACTIVE && $stable(clk_ctrl_out)
    && !global_reset_out)
    else $error("repeated ACTIVE disturbed state");

  c_sleep_wake: cover property (
    state_q == pwr_pkg::ST_SLEEP ##1 state_q == pwr_pkg::ST_ACTIVE);
  c_pin_pd_wake: cover property (
    state_q == pwr_pkg::ST_POWERDOWN && !pd_by_cmd_q
    ##1 state_q == pwr_pkg::ST_ACTIVE);
  c_pulse_reset: cover property (hw_reset && ce_in);
  c_boot_done: cover property ($fell(boot_busy_out));
endmodule

// ### dv/host_model.sv
// Host side model: sends power command frames, drives the power-down pin.
// Assumes the device samples the link with a much faster core clock.
`timescale 1ns/1ps
module host_model #(
  parameter int unsigned HALF_NS = 80
) (
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out,
  output logic pd_n_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b1;
    pd_n_out = 1'b1;
  end

  // Mode 0, MSB first; link clock stands still between frames
  task automatic send_cmd(input logic [7:0] op, input logic [7:0] arg);
    logic [23:0] frame;
    frame = {op, arg, 8'h00};
    #7;
    cs_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi_out = frame[i];
      #(HALF_NS);
      sck_out = 1'b1;
      #(HALF_NS);
      sck_out = 1'b0;
    end
    #(HALF_NS);
    cs_n_out = 1'b1;
    // Released data line must not keep looking valid
    mosi_out = ~mosi_out;
    #(HALF_NS);
  endtask

  task automatic set_pd(input logic level);
    pd_n_out = level;
  endtask

  // Pin goes high before the wake frame, never the other way round
  task automatic wake();
    set_pd(1'b1);
    #(HALF_NS);
    send_cmd(pwr_pkg::CMD_ACTIVE, 8'h00);
  endtask
endmodule

// ### dv/tb_power_state_controller.sv
// Self-checking bench for the power-state controller.
// Assumes host_model on the link; pulses are counted as they happen.
`timescale 1ns/1ps
module tb_power_state_controller;
  logic clk_in, rst_n_in, ce, por_n_in, t_res, t_det, tp_n, irq;
  logic sck, cs_n, mosi, pd_n;
  pwr_pkg::pwr_state_t st;
  pwr_pkg::clk_ctrl_t ctrl;
  logic hold, boot, grst, srst, cext, int_v, int_oe;
  logic [7:0] pdst;
  int fails, samples_checked, gr_cnt, sr_cnt, g0, s0;

  host_model i_host_model (.sck_out(sck), .cs_n_out(cs_n),
    .mosi_out(mosi), .pd_n_out(pd_n));

  // Short counts keep the run small; expectations use the same figures
  power_state_controller #(.PD_PULSE_CYCLES(40), .BOOT_CYCLES(20))
  i_power_state_controller (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce), .por_n_in(por_n_in), .power_down_pin_n_in(pd_n),
    .spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
    .touch_resistive_in(t_res), .touch_detect_in(t_det),
    .touch_panel_interrupt_input_n_in(tp_n), .irq_req_in(irq),
    .power_state_out(st), .clk_ctrl_out(ctrl), .pin_hold_out(hold),
    .boot_busy_out(boot), .global_reset_out(grst),
    .soft_reset_out(srst), .clk_ext_out(cext), .pd_pin_state_out(pdst),
    .host_int_out(int_v), .host_int_oe_out(int_oe));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (grst === 1'b1) gr_cnt++;
    if (srst === 1'b1) sr_cnt++;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_st(input pwr_pkg::pwr_state_t s,
                        input pwr_pkg::clk_ctrl_t c);
    chk("power_state", 8'(s), 8'(st));
    chk("clk_ctrl", 8'(c), 8'(ctrl));
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] arg);
    i_host_model.send_cmd(op, arg);
    wait_cyc(4);
  endtask

  task automatic t_reset();
    chk_st(pwr_pkg::ST_SLEEP, pwr_pkg::CTRL_SLEEP);
    chk("pin_hold", 8'h01, 8'(hold));
    chk("int_oe", 8'h00, 8'(int_oe));
    chk("int_val", 8'h00, 8'(int_v));
    $display("test reset done");
  endtask

  task automatic t_wake_sleep();
    cmd(pwr_pkg::CMD_ACTIVE, 8'h00);
    chk_st(pwr_pkg::ST_ACTIVE, pwr_pkg::CTRL_ACTIVE);
    chk("pin_hold", 8'h00, 8'(hold));
    chk("boot_busy", 8'h01, 8'(boot));
    wait_cyc(20);
    chk("boot_busy", 8'h00, 8'(boot));
    g0 = gr_cnt;
    cmd(pwr_pkg::CMD_ACTIVE, 8'h00);
    chk_st(pwr_pkg::ST_ACTIVE, pwr_pkg::CTRL_ACTIVE);
    chk("boot_busy", 8'h00, 8'(boot));
    chk("gr_pulses", 8'(g0), 8'(gr_cnt));
    irq = 1'b1;
    tp_n = 1'b0;
    wait_cyc(4);
    chk("int_oe", 8'h01, 8'(int_oe));
    irq = 1'b0;
    wait_cyc(4);
    chk("int_oe", 8'h00, 8'(int_oe));
    tp_n = 1'b1;
    $display("test wake from sleep done");
  endtask

  task automatic t_standby();
    cmd(pwr_pkg::CMD_STANDBY, 8'h00);
    chk_st(pwr_pkg::ST_STANDBY, pwr_pkg::CTRL_STANDBY);
    chk("pin_hold", 8'h01, 8'(hold));
    t_res = 1'b1;
    t_det = 1'b1;
    wait_cyc(4);
    chk("int_oe", 8'h01, 8'(int_oe));
    t_det = 1'b0;
    wait_cyc(4);
    chk("int_oe", 8'h00, 8'(int_oe));
    cmd(pwr_pkg::CMD_ACTIVE, 8'h00);
    chk_st(pwr_pkg::ST_ACTIVE, pwr_pkg::CTRL_ACTIVE);
    chk("boot_busy", 8'h00, 8'(boot));
    $display("test standby done");
  endtask

  task automatic t_cmd_pd();
    cmd(pwr_pkg::CMD_SLEEP, 8'h00);
    chk_st(pwr_pkg::ST_SLEEP, pwr_pkg::CTRL_SLEEP);
    t_det = 1'b1;
    wait_cyc(4);
    chk("int_oe", 8'h01, 8'(int_oe));
    t_res = 1'b0;
    t_det = 1'b0;
    tp_n = 1'b0;
    wait_cyc(4);
    chk("int_oe", 8'h01, 8'(int_oe));
    tp_n = 1'b1;
    cmd(pwr_pkg::CMD_CLK_EXT, 8'h00);
    cmd(pwr_pkg::CMD_PIN_PD, 8'h5A);
    chk("clk_ext", 8'h01, 8'(cext));
    cmd(pwr_pkg::CMD_PWRDOWN, 8'h00);
    chk_st(pwr_pkg::ST_POWERDOWN, pwr_pkg::CTRL_POWERDOWN);
    t_res = 1'b1;
    t_det = 1'b1;
    wait_cyc(4);
    chk("int_oe", 8'h00, 8'(int_oe));
    t_res = 1'b0;
    tp_n = 1'b0;
    wait_cyc(4);
    chk("int_oe", 8'h01, 8'(int_oe));
    tp_n = 1'b1;
    t_det = 1'b0;
    cmd(pwr_pkg::CMD_STANDBY, 8'h00);
    chk_st(pwr_pkg::ST_POWERDOWN, pwr_pkg::CTRL_POWERDOWN);
    i_host_model.set_pd(1'b0);
    cmd(pwr_pkg::CMD_ACTIVE, 8'h00);
    chk_st(pwr_pkg::ST_POWERDOWN, pwr_pkg::CTRL_POWERDOWN);
    g0 = gr_cnt;
    s0 = sr_cnt;
    i_host_model.wake();
    wait_cyc(4);
    chk_st(pwr_pkg::ST_ACTIVE, pwr_pkg::CTRL_ACTIVE);
    chk("gr_pulses", 8'(g0 + 1), 8'(gr_cnt));
    chk("sr_pulses", 8'(s0 + 1), 8'(sr_cnt));
    chk("clk_ext", 8'h00, 8'(cext));
    chk("pd_pin_state", 8'h5A, pdst);
    wait_cyc(22);
    $display("test command powerdown done");
  endtask

  task automatic t_pin_pd();
    i_host_model.set_pd(1'b0);
    wait_cyc(5);
    chk_st(pwr_pkg::ST_POWERDOWN, pwr_pkg::CTRL_POWERDOWN);
    g0 = gr_cnt;
    s0 = sr_cnt;
    i_host_model.wake();
    wait_cyc(4);
    chk_st(pwr_pkg::ST_ACTIVE, pwr_pkg::CTRL_ACTIVE);
    chk("gr_pulses", 8'(g0 + 1), 8'(gr_cnt));
    chk("sr_pulses", 8'(s0), 8'(sr_cnt));
    wait_cyc(22);
    $display("test pin powerdown done");
  endtask

  task automatic t_hw_pulse();
    cmd(pwr_pkg::CMD_STANDBY, 8'h00);
    g0 = gr_cnt;
    i_host_model.set_pd(1'b0);
    wait_cyc(10);
    i_host_model.set_pd(1'b1);
    wait_cyc(6);
    chk_st(pwr_pkg::ST_STANDBY, pwr_pkg::CTRL_STANDBY);
    i_host_model.set_pd(1'b0);
    wait_cyc(45);
    i_host_model.set_pd(1'b1);
    wait_cyc(6);
    chk_st(pwr_pkg::ST_SLEEP, pwr_pkg::CTRL_SLEEP);
    chk("gr_pulses", 8'(g0 + 1), 8'(gr_cnt));
    s0 = sr_cnt;
    cmd(pwr_pkg::CMD_RST_PULSE, 8'h00);
    chk("sr_pulses", 8'(s0 + 1), 8'(sr_cnt));
    chk_st(pwr_pkg::ST_SLEEP, pwr_pkg::CTRL_SLEEP);
    cmd(pwr_pkg::CMD_STANDBY, 8'h00);
    chk_st(pwr_pkg::ST_STANDBY, pwr_pkg::CTRL_STANDBY);
    cmd(pwr_pkg::CMD_SLEEP, 8'h00);
    chk_st(pwr_pkg::ST_SLEEP, pwr_pkg::CTRL_SLEEP);
    $display("test hardware pulse done");
  endtask

  task automatic t_por();
    cmd(pwr_pkg::CMD_ACTIVE, 8'h00);
    g0 = gr_cnt;
    // Enable low must freeze everything, synchronisers too
    ce = 1'b0;
    por_n_in = 1'b0;
    wait_cyc(6);
    chk_st(pwr_pkg::ST_ACTIVE, pwr_pkg::CTRL_ACTIVE);
    chk("gr_frozen", 8'(g0), 8'(gr_cnt));
    ce = 1'b1;
    wait_cyc(6);
    por_n_in = 1'b1;
    wait_cyc(4);
    chk_st(pwr_pkg::ST_SLEEP, pwr_pkg::CTRL_SLEEP);
    chk("gr_seen", 8'h01, 8'(gr_cnt > g0));
    $display("test power-on reset done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_n_in = 1'b0;
    ce = 1'b1;
    por_n_in = 1'b1;
    t_res = 1'b0;
    t_det = 1'b0;
    tp_n = 1'b1;
    irq = 1'b0;
    wait_cyc(12);
    rst_n_in = 1'b1;
    wait_cyc(3);
    t_reset();
    t_wake_sleep();
    t_standby();
    t_cmd_pd();
    t_pin_pd();
    t_hw_pulse();
    t_por();
    close_out();
  end

  // Whole run needs about 75 us; allow generous margin
  initial begin
    #1000000;
    fails++;
    close_out();
  end
endmodule
